// ===== rtl/logic_cells_pkg.sv
// constants and carrier types for the scanned logic cell bank
package logic_cells_pkg;
  // ==========================================================
  // scan timing
  localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
  localparam int unsigned SCAN_PERIOD_MS   = 10;
  localparam int unsigned SCAN_CYCLES_DEF  = CLK_FREQ_HZ / 1000 * SCAN_PERIOD_MS;
  localparam int unsigned SCAN_CNT_W       = 20;
  localparam int unsigned DELAY_STEP_MS    = 100;
  localparam int unsigned DELAY_TICKS_STEP = DELAY_STEP_MS / SCAN_PERIOD_MS;
  localparam int unsigned DELAY_CNT_W      = 16;

  // ==========================================================
  // flag numbering
  localparam int CTL_LO         = 147;
  localparam int CTL_HI         = 187;
  localparam int STS_LO         = 115;
  localparam int STS_HI         = 131;
  localparam int TMPL_CELLS     = 3;
  localparam int QUAD_CELLS     = 8;
  localparam int TMPL_CTL_BASE  = 147;
  localparam int TMPL_STS_BASE  = 115;
  localparam int TMPL_STRIDE    = 3;
  localparam int TMPL_IN1_OFS   = 1;
  localparam int TMPL_IN2_OFS   = 2;
  localparam int TMPL_DLY_OFS   = 1;
  localparam int TMPL_BOOL_OFS  = 2;
  localparam int QUAD_CTL_BASE  = 156;
  localparam int QUAD_STS_BASE  = 124;
  localparam int QUAD_STRIDE    = 4;

  // ==========================================================
  // setting codes
  localparam logic [3:0] FN_AND     = 4'h1;
  localparam logic [3:0] FN_NAND    = 4'h2;
  localparam logic [3:0] FN_OR      = 4'h3;
  localparam logic [3:0] FN_NOR     = 4'h4;
  localparam logic [3:0] FN_XOR     = 4'h5;
  localparam logic [3:0] FN_XNOR    = 4'h6;
  localparam logic [3:0] FN_TWO_OFS = 4'h6;
  localparam logic [3:0] FN_TWO_MAX = 4'hc;
  localparam logic [3:0] CMP_EQ     = 4'h1;
  localparam logic [3:0] CMP_NE     = 4'h2;
  localparam logic [3:0] CMP_GT     = 4'h3;
  localparam logic [3:0] CMP_LE     = 4'h4;
  localparam logic [3:0] CMP_LT     = 4'h5;
  localparam logic [3:0] CMP_GE     = 4'h6;
  localparam logic [3:0] CMP_ABS_OFS = 4'h4;
  localparam logic [3:0] CMP_ABS_MAX = 4'ha;
  localparam logic [1:0] DSRC_CMP   = 2'h1;
  localparam logic [1:0] DSRC_FLAG  = 2'h2;

  typedef logic signed [15:0] sample_type;

  // settings of one comparator-delay-boolean cell, in slot order
  typedef struct packed {
    sample_type  threshold;
    logic [3:0]  cmp_mode;
    logic [1:0]  delay_src;
    logic [12:0] delay_time;
    logic [3:0]  func;
  } tmpl_cfg_type;
endpackage

// ===== rtl/logic_cells.sv
// scanned bank of configurable logic cells j..t
`timescale 1ns/1ps

module logic_cells #(
  parameter int unsigned SCAN_CYCLES = logic_cells_pkg::SCAN_CYCLES_DEF
) (
  input  wire logic                                                   clk_sys,
  input  wire logic                                                   rst_n,
  input  wire logic                                                   clk_en,
  input  wire logic [logic_cells_pkg::CTL_HI:logic_cells_pkg::CTL_LO] control_input_flag,
  input  wire logic_cells_pkg::tmpl_cfg_type [2:0]                    tmpl_cfg,
  input  wire logic_cells_pkg::sample_type [2:0]                      cmp_sample,
  input  wire logic [7:0][3:0]                                        quad_func,
  output logic [logic_cells_pkg::STS_HI:logic_cells_pkg::STS_LO]      status_output_flag,
  output logic                                                        scan_tick_r
);
  import logic_cells_pkg::*;

  // ==========================================================
  // shared boolean pick
  function automatic logic bool_pick(input logic [3:0] code, input logic a_all,
                                     input logic o_any, input logic x_odd);
    logic r;
    r = 1'b0;
    unique case (code)
      FN_AND:  r = a_all;
      FN_NAND: r = ~a_all;
      FN_OR:   r = o_any;
      FN_NOR:  r = ~o_any;
      FN_XOR:  r = x_odd;
      FN_XNOR: r = ~x_odd;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic cmp_eval(input logic [3:0] mode, input sample_type v,
                                    input sample_type t);
    logic signed [16:0] a;
    logic signed [16:0] b;
    logic [3:0]         m;
    logic               r;
    a = {v[15], v};
    b = {t[15], t};
    m = mode;
    r = 1'b0;
    if (mode > CMP_GE && mode <= CMP_ABS_MAX) begin
      a = (a < 0) ? -a : a;
      b = (b < 0) ? -b : b;
      m = mode - CMP_ABS_OFS;
    end
    unique case (m)
      CMP_EQ:  r = (a == b);
      CMP_NE:  r = (a != b);
      CMP_GT:  r = (a > b);
      CMP_LE:  r = (a <= b);
      CMP_LT:  r = (a < b);
      CMP_GE:  r = (a >= b);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // scan tick
  logic [SCAN_CNT_W-1:0] scan_cnt_r;
  logic                  scan_tick;

  assign scan_tick = clk_en && (scan_cnt_r == SCAN_CNT_W'(SCAN_CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scan_cnt_r <= '0;
    end else if (clk_en) begin
      scan_cnt_r <= scan_tick ? '0 : scan_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scan_tick_r <= 1'b0;
    end else if (clk_en) begin
      scan_tick_r <= scan_tick;
    end
  end

  // ==========================================================
  // comparator-delay-boolean cells j, k, l
  logic [2:0] dly_next;
  logic [2:0] cmp_now;
  logic [2:0] tmpl_out;

  for (genvar c = 0; c < TMPL_CELLS; c++) begin : g_tmpl
    localparam int CFD = TMPL_CTL_BASE + c * TMPL_STRIDE;
    localparam int SFB = TMPL_STS_BASE + c * TMPL_STRIDE;
    logic [DELAY_CNT_W-1:0] dly_cnt_r;
    logic                   dly_out_r;
    logic                   dly_in;
    logic [DELAY_CNT_W-1:0] dly_target;
    logic [3:0]             two_code;

    assign cmp_now[c]  = cmp_eval(tmpl_cfg[c].cmp_mode, cmp_sample[c],
                                  tmpl_cfg[c].threshold);
    // first flag of each group feeds the delay when delay_src is DSRC_FLAG, the comparator when DSRC_CMP, else low
    assign dly_in = (tmpl_cfg[c].delay_src == DSRC_CMP)  ? cmp_now[c] :
                    (tmpl_cfg[c].delay_src == DSRC_FLAG) ? control_input_flag[CFD] :
                    1'b0;
    assign dly_target = DELAY_CNT_W'(tmpl_cfg[c].delay_time * DELAY_TICKS_STEP);
    assign dly_next[c] = dly_in && (dly_out_r || dly_cnt_r >= dly_target);
    assign two_code = tmpl_cfg[c].func - FN_TWO_OFS;

    // rising edge delayed, falling edge immediate
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        dly_cnt_r <= '0;
        dly_out_r <= 1'b0;
      end else if (scan_tick) begin
        dly_out_r <= dly_next[c];
        if (!dly_in) begin
          dly_cnt_r <= '0;
        end else if (!dly_next[c]) begin
          dly_cnt_r <= dly_cnt_r + 1'b1;
        end
      end
    end

    always_comb begin
      logic a;
      logic b;
      logic d;
      d = dly_next[c];
      a = control_input_flag[CFD + TMPL_IN1_OFS];
      b = control_input_flag[CFD + TMPL_IN2_OFS];
      if (tmpl_cfg[c].func > FN_XNOR && tmpl_cfg[c].func <= FN_TWO_MAX) begin
        tmpl_out[c] = bool_pick(two_code, control_input_flag[CFD] & a,
                                control_input_flag[CFD] | a,
                                control_input_flag[CFD] ^ a);
      end else begin
        tmpl_out[c] = bool_pick(tmpl_cfg[c].func, d & a & b, d | a | b, d ^ a ^ b);
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        status_output_flag[SFB +: TMPL_STRIDE] <= '0;
      end else if (scan_tick) begin
        status_output_flag[SFB]     <= cmp_now[c];
        status_output_flag[SFB + TMPL_DLY_OFS]  <= dly_next[c];
        status_output_flag[SFB + TMPL_BOOL_OFS] <= tmpl_out[c];
      end
    end
  end

  // ==========================================================
  // four-input boolean cells m..t
  for (genvar q = 0; q < QUAD_CELLS; q++) begin : g_quad
    localparam int CFQ = QUAD_CTL_BASE + q * QUAD_STRIDE;
    logic [3:0] qin;

    assign qin = control_input_flag[CFQ +: QUAD_STRIDE];

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        status_output_flag[QUAD_STS_BASE + q] <= 1'b0;
      end else if (scan_tick) begin
        status_output_flag[QUAD_STS_BASE + q] <=
          bool_pick(quad_func[q], &qin, |qin, ^qin);
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_k_flag_path;
    scan_tick && tmpl_cfg[1].delay_src == DSRC_FLAG && tmpl_cfg[1].delay_time == '0;
  endsequence

  property p_quad_m_and;
    scan_tick && quad_func[0] == FN_AND |=> status_output_flag[124] == $past(&control_input_flag[159:156]);
  endproperty
  a_quad_m_and: assert property (p_quad_m_and) else $error("cell m and wrong");

  property p_quad_t_xnor;
    scan_tick && quad_func[7] == FN_XNOR |=> status_output_flag[131] == !$past(^control_input_flag[187:184]);
  endproperty
  a_quad_t_xnor: assert property (p_quad_t_xnor) else $error("cell t xnor wrong");

  property p_quad_n_nor;
    scan_tick && quad_func[1] == FN_NOR |=> status_output_flag[125] == !$past(|control_input_flag[163:160]);
  endproperty
  a_quad_n_nor: assert property (p_quad_n_nor) else $error("cell n nor wrong");

  property p_bad_func;
    scan_tick && (quad_func[3] == 4'h0 || quad_func[3] > FN_XNOR) |=> !status_output_flag[127];
  endproperty
  a_bad_func: assert property (p_bad_func) else $error("illegal selector not low");

  property p_hold;
    !scan_tick |=> $stable(status_output_flag);
  endproperty
  a_hold: assert property (p_hold) else $error("flags moved between scans");

  property p_tick_spacing;
    scan_tick |=> !scan_tick [*2];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("scan ticks too close");

  property p_j_and3;
    scan_tick && tmpl_cfg[0].func == FN_AND |=> status_output_flag[117] ==
      ($past(dly_next[0]) & $past(control_input_flag[148]) & $past(control_input_flag[149]));
  endproperty
  a_j_and3: assert property (p_j_and3) else $error("cell j boolean wrong");

  property p_k_delay_flag;
    s_k_flag_path |=> status_output_flag[119] == $past(control_input_flag[150]);
  endproperty
  a_k_delay_flag: assert property (p_k_delay_flag) else $error("cell k delay wrong");

  property p_l_cmp_gt;
    scan_tick && tmpl_cfg[2].cmp_mode == CMP_GT |=>
      status_output_flag[121] == ($past(cmp_sample[2]) > $past(tmpl_cfg[2].threshold));
  endproperty
  a_l_cmp_gt: assert property (p_l_cmp_gt) else $error("cell l comparator wrong");
endmodule

// ===== bench/flag_patch_net.sv
// model of the flag patching network that feeds the cell bank
`timescale 1ns/1ps
module flag_patch_net (
  input  wire logic [187:147] direct_flags,
  input  wire logic [131:115] status_output_flag,
  input  wire logic           chain_en,
  input  wire logic [7:0]     chain_src,
  input  wire logic [7:0]     chain_dst,
  output logic      [187:147] control_input_flag
);
  // unused inputs come tied from the bench: high for and, low for or/xor
  always_comb begin
    control_input_flag = direct_flags;
    if (chain_en) begin
      control_input_flag[chain_dst] = status_output_flag[chain_src];
    end
  end
endmodule

// ===== bench/logic_cells_test.sv
// self-checking bench for the scanned logic cell bank
`timescale 1ns/1ps
module logic_cells_test;
  import logic_cells_pkg::*;
  localparam int SC = 8;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic               clk_en = 1'b1;
  logic               chain_en = 1'b0;
  logic [7:0]         chain_src = 8'h7c;
  logic [7:0]         chain_dst = 8'ha0;
  logic [187:147]     direct_flags = '0;
  logic [187:147]     control_input_flag;
  logic [131:115]     status_output_flag;
  logic               scan_tick_r;
  tmpl_cfg_type [2:0] tmpl_cfg = '0;
  sample_type [2:0]   cmp_sample = '0;
  logic [7:0][3:0]    quad_func = '0;
  logic [3:0]         codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
  logic [8:0]         e;
  logic [2:0]         x;
  int                 miscompares = 0;
  int                 n_checks = 0;

  logic_cells #(.SCAN_CYCLES(SC)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .control_input_flag(control_input_flag), .tmpl_cfg(tmpl_cfg), .cmp_sample(cmp_sample),
    .quad_func(quad_func), .status_output_flag(status_output_flag), .scan_tick_r(scan_tick_r));
  flag_patch_net net (.direct_flags(direct_flags), .status_output_flag(status_output_flag),
    .chain_en(chain_en), .chain_src(chain_src), .chain_dst(chain_dst),
    .control_input_flag(control_input_flag));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // waits for the next scan, optionally checking the spacing from the last one
  task automatic scan(input bit gap_chk);
    int n;
    for (n = 1; n <= 4 * SC; n++) begin
      @(posedge clk_sys);
      #1;
      if (scan_tick_r === 1'b1) break;
    end
    if (n > 4 * SC) begin
      miscompares++;
      print_verdict();
    end else if (gap_chk) begin
      chk(n, SC);
    end
  endtask

  function automatic logic quad(input logic [3:0] f, input logic [3:0] v);
    case (f)
      4'h1: return &v;
      4'h2: return ~&v;
      4'h3: return |v;
      4'h4: return ~|v;
      4'h5: return ^v;
      4'h6: return ~^v;
      default: return 1'b0;
    endcase
  endfunction

  // spare inputs padded high for and/nand, low otherwise
  function automatic logic tmpl(input logic [3:0] f, input logic d, a, b);
    if (f >= 4'h7 && f <= 4'hc) return tmpl(f - 4'h6, d, a, f <= 4'h8);
    return quad(f, {d, a, b, f <= 4'h2});
  endfunction

  function automatic logic cmp(input logic [3:0] m, input sample_type s, t);
    sample_type v;
    v = (m > 4'h6 && s < 0) ? -s : s;
    case (m > 4'h6 ? m - 4'h4 : m)
      4'h1: return v == t;
      4'h2: return v != t;
      4'h3: return v > t;
      4'h4: return v <= t;
      4'h5: return v < t;
      4'h6: return v >= t;
      default: return 1'b0;
    endcase
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    chk(status_output_flag, 17'h00000);
    chk(scan_tick_r, 1'b0);
    rst_n = 1'b1;
    scan(0);
    // four-input cells: codes 0..7 and 15, all patterns, distinct per cell
    for (int k = 0; k < 9; k++) begin
      for (int p = 0; p < 16; p++) begin
        for (int c = 0; c < 8; c++) begin
          quad_func[c] = codes[(k + c) % 9];
          direct_flags[156 + 4*c +: 4] = 4'(p + 3*c);
          e[c] = quad(quad_func[c], 4'(p + 3*c));
        end
        scan(1);
        chk(status_output_flag[127:124], e[3:0]);
        chk(status_output_flag[131:128], e[7:4]);
      end
    end
    // template cells: comparator, zero delay, boolean codes 0..12
    for (int f = 0; f < 13; f++) begin
      for (int p = 0; p < 8; p++) begin
        for (int i = 0; i < 3; i++) begin
          tmpl_cfg[i] = '{16'sh0005, 4'(f), 2'h2, 13'h0000, 4'(f)};
          cmp_sample[i] = sample_type'(p * 3 - 10 + i);
          x = 3'(p + i);
          direct_flags[147 + 3*i +: 3] = x;
          e[3*i +: 3] = {tmpl(4'(f), x[0], x[1], x[2]), x[0], cmp(4'(f), cmp_sample[i], 16'sh0005)};
        end
        scan(1);
        chk(status_output_flag[117:115], e[2:0]);
        chk(status_output_flag[120:118], e[5:3]);
        chk(status_output_flag[123:121], e[8:6]);
      end
    end
    // delay of one step on k, comparator-sourced delay on l
    tmpl_cfg[1].delay_time = 13'h0001;
    tmpl_cfg[2] = '{16'sh0005, 4'h1, 2'h1, 13'h0000, 4'h1};
    cmp_sample[2] = 16'sh0005;
    direct_flags[155:150] = 6'h00;
    scan(1);
    direct_flags[150] = 1'b1;
    for (int n = 1; n <= 12; n++) begin
      scan(1);
      chk(status_output_flag[119], n > DELAY_TICKS_STEP);
    end
    chk(status_output_flag[122], 1'b1);
    direct_flags[150] = 1'b0;
    scan(1);
    chk(status_output_flag[119], 1'b0);
    // chained m into n shows one scan later
    quad_func[0] = FN_OR;
    quad_func[1] = FN_AND;
    direct_flags[163:156] = 8'he0;
    chain_en = 1'b1;
    scan(1);
    direct_flags[156] = 1'b1;
    scan(1);
    chk(status_output_flag[125:124], 2'h1);
    scan(1);
    chk(status_output_flag[125:124], 2'h3);
    // frozen clock enable: nothing moves
    direct_flags[156] = 1'b0;
    clk_en = 1'b0;
    repeat (3 * SC) @(posedge clk_sys);
    #1;
    chk(scan_tick_r, 1'b1);
    chk(status_output_flag[124], 1'b1);
    clk_en = 1'b1;
    scan(1);
    chk(status_output_flag[124], 1'b0);
    // second reset in mid-run
    rst_n = 1'b0;
    @(posedge clk_sys);
    #1;
    chk(status_output_flag, 17'h00000);
    chk(scan_tick_r, 1'b0);
    rst_n = 1'b1;
    scan(1);
    chk(status_output_flag[125:124], 2'h0);
    print_verdict();
  end
endmodule
